// File: rnd_pkg.sv
// package: constants and carriers for the reset, nmi and debug entry block
package rnd_pkg;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_PERIOD_PS = 10000;
  localparam int MIN_RST_LOW_NS = 100;
  localparam int MIN_RST_LOW_CLK = 2;
  // least low time in cycles, rounded up, plus the clock margin
  localparam int MIN_RST_LOW_CYC =
    (MIN_RST_LOW_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS
    + MIN_RST_LOW_CLK;
  localparam int SYNC_STAGES = 3;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic RST_LEVEL_ACTIVE = 1'h0;
  localparam logic [1:0] STARTUP_CFG_RESET = 2'h0;

  // ************************************************************
  // carriers
  // ************************************************************
  typedef struct packed {
    logic reset_input_pin_n;
    logic nmi_pin_n;
    logic debug_reset_pin;
    logic startup_cfg_pin_a;
    logic startup_cfg_pin_b;
  } rnd_pins_t;

  typedef struct packed {
    logic debug_active;
    logic hw_cfg_enable;
    logic [1:0] startup_cfg;
  } rnd_boot_t;

  typedef enum logic [2:0] {
    ST_RESET = 3'h1,
    ST_RUN = 3'h2,
    ST_PDOWN = 3'h4
  } rnd_state_t;

endpackage

// File: rnd_sync.sv
// three-stage pin synchroniser with agreement of the last two stages
`timescale 1ns/1ps
module rnd_sync #(
  parameter int WIDTH = 5,
  parameter logic [WIDTH-1:0] INIT = '1
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // data
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic [WIDTH-1:0] next_sync;

  // ************************************************************
  // per bit filter
  // ************************************************************
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      // a change counts only once stage two and three agree
      always_comb begin
        next_sync[g] = o_sync[g];
        if (stage2[g] == stage3[g]) begin
          next_sync[g] = stage3[g];
        end
      end
    end
  endgenerate

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      meta <= INIT;
      stage2 <= INIT;
      stage3 <= INIT;
      o_sync <= INIT;
    end else begin
      meta <= i_async;
      stage2 <= meta;
      stage3 <= stage2;
      o_sync <= next_sync;
    end
  end
endmodule

// File: rnd_reset_nmi_debug_entry.sv
// reset qualification, nmi trap request, power-down gate and debug entry
// How it works
// - reset stays asserted for as long as the reset pin is low
// - a falling edge on the nmi pin requests the nmi trap
// - power-down instruction with nmi low enters power-down mode
// - power-down instruction with nmi high keeps normal running
// - debug reset pin high at reset release enables debug and config
// - after debug entry a low debug reset pin resets the debug system
// - startup configuration pins are sampled at the end of reset
`timescale 1ns/1ps
module rnd_reset_nmi_debug_entry
  import rnd_pkg::*;
#(
  parameter int MIN_LOW_CYC = rnd_pkg::MIN_RST_LOW_CYC
) (
  // clock and power-on reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // device pins
  input wire rnd_pkg::rnd_pins_t i_pins,
  // core side
  input wire logic i_power_down_instruction,
  input wire logic i_wake,
  input wire logic i_nmi_ack,
  // outputs
  output logic o_sys_reset,
  output logic o_nmi_trap_req,
  output logic o_power_down,
  output logic o_debug_reset,
  output rnd_pkg::rnd_boot_t o_boot
);
  import rnd_pkg::*;

  localparam int CW = $clog2(MIN_LOW_CYC + 1);
  localparam logic [CW-1:0] LOW_LIMIT = CW'(MIN_LOW_CYC);

  rnd_pins_t pins_s;
  rnd_state_t state;
  rnd_state_t next_state;
  logic [CW-1:0] low_cnt;
  logic [CW-1:0] next_low_cnt;
  logic nmi_prev;
  logic next_nmi_prev;
  logic nmi_req;
  logic next_nmi_req;
  logic dbg_rst;
  logic next_dbg_rst;
  rnd_boot_t boot;
  rnd_boot_t next_boot;
  logic release_now;
  logic debug_end;
  logic sys_reset;
  logic next_sys_reset;
  logic power_down;
  logic next_power_down;

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  // synchronise pins
  rnd_sync #(
    .WIDTH($bits(rnd_pins_t)),
    .INIT({1'h1, 1'h1, 1'h0, 1'h0, 1'h0})
  ) u_sync (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_async(i_pins),
    .o_sync(pins_s)
  );

  // ************************************************************
  // release and debug end events
  // ************************************************************
  always_comb begin
    release_now = 1'h0;
    debug_end = 1'h0;
    // short glitches are counted, release needs a full low time
    if (state == ST_RESET && low_cnt == LOW_LIMIT &&
        pins_s.reset_input_pin_n != RST_LEVEL_ACTIVE) begin
      release_now = 1'h1;
    end
    if (state == ST_RUN && boot.debug_active &&
        !pins_s.debug_reset_pin) begin
      debug_end = 1'h1;
    end
  end

  // ************************************************************
  // reset and power-down state
  // ************************************************************
  always_comb begin
    next_state = state;
    next_low_cnt = low_cnt;
    if (pins_s.reset_input_pin_n == RST_LEVEL_ACTIVE) begin
      next_state = ST_RESET;
      if (low_cnt != LOW_LIMIT) begin
        next_low_cnt = low_cnt + CW'(1);
      end
    end else begin
      case (state)
        ST_RESET: begin
          if (release_now) begin
            next_state = ST_RUN;
          end
          next_low_cnt = '0;
        end
        ST_RUN: begin
          if (i_power_down_instruction &&
              pins_s.nmi_pin_n == 1'h0) begin
            next_state = ST_PDOWN;
          end
        end
        ST_PDOWN: begin
          if (i_wake) begin
            next_state = ST_RUN;
          end
        end
        default: begin
          next_state = ST_RESET;
        end
      endcase
    end
    // status flops track the state, so outputs carry no decode
    next_sys_reset = (next_state == ST_RESET);
    next_power_down = (next_state == ST_PDOWN);
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      state <= ST_RESET;
      low_cnt <= '0;
      sys_reset <= 1'h1;
      power_down <= 1'h0;
    end else begin
      state <= next_state;
      low_cnt <= next_low_cnt;
      sys_reset <= next_sys_reset;
      power_down <= next_power_down;
    end
  end

  // ************************************************************
  // boot capture
  // ************************************************************
  always_comb begin
    next_boot = boot;
    if (release_now) begin
      next_boot.debug_active = pins_s.debug_reset_pin;
      next_boot.hw_cfg_enable = pins_s.debug_reset_pin;
      next_boot.startup_cfg = {pins_s.startup_cfg_pin_b,
                               pins_s.startup_cfg_pin_a};
    end
    if (debug_end) begin
      next_boot.debug_active = 1'h0;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      boot <= '{1'h0, 1'h0, STARTUP_CFG_RESET};
    end else begin
      boot <= next_boot;
    end
  end

  // ************************************************************
  // nmi trap request
  // ************************************************************
  always_comb begin
    next_nmi_prev = pins_s.nmi_pin_n;
    next_nmi_req = nmi_req;
    if (i_nmi_ack) begin
      next_nmi_req = 1'h0;
    end
    // falling edge sets trap, set wins over ack
    if (state != ST_RESET && nmi_prev && !pins_s.nmi_pin_n) begin
      next_nmi_req = 1'h1;
    end
    // a pending trap does not survive reset
    if (state == ST_RESET) begin
      next_nmi_req = 1'h0;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      nmi_prev <= 1'h1;
      nmi_req <= 1'h0;
    end else begin
      nmi_prev <= next_nmi_prev;
      nmi_req <= next_nmi_req;
    end
  end

  // ************************************************************
  // debug system reset pulse
  // ************************************************************
  always_comb begin
    next_dbg_rst = 1'h0;
    if (debug_end) begin
      next_dbg_rst = 1'h1;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      dbg_rst <= 1'h0;
    end else begin
      dbg_rst <= next_dbg_rst;
    end
  end

  assign o_sys_reset = sys_reset;
  assign o_power_down = power_down;
  assign o_nmi_trap_req = nmi_req;
  assign o_debug_reset = dbg_rst;
  assign o_boot = boot;
endmodule

// File: rnd_chk.sv
// checker: port relations of the reset, nmi and debug entry block
`timescale 1ns/1ps
module rnd_chk
  import rnd_pkg::*;
(
  // clock, reset and inputs
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire rnd_pkg::rnd_pins_t i_pins,
  input wire logic i_power_down_instruction,
  input wire logic i_wake,
  input wire logic i_nmi_ack,
  // outputs
  input wire logic o_sys_reset,
  input wire logic o_nmi_trap_req,
  input wire logic o_power_down,
  input wire logic o_debug_reset,
  input wire rnd_pkg::rnd_boot_t o_boot
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  rst_hold_a: assert property (!i_pins.reset_input_pin_n [*6]
    |-> o_sys_reset) else $error("reset not entered");
  nmi_req_a: assert property ($fell(i_pins.nmi_pin_n) && !o_sys_reset
    |-> ##[1:6] o_nmi_trap_req) else $error("nmi request missing");
  nmi_hold_a: assert property (o_nmi_trap_req && !i_nmi_ack
    |=> o_nmi_trap_req || o_sys_reset) else $error("nmi request lost");
  pd_enter_a: assert property (!i_pins.nmi_pin_n
    && !$past(i_pins.nmi_pin_n, 5) && i_power_down_instruction && !i_wake
    && i_pins.reset_input_pin_n |=> o_power_down) else $error("no pdown");
  pd_refuse_a: assert property (i_pins.nmi_pin_n
    && $past(i_pins.nmi_pin_n, 5) && !o_power_down
    |=> !o_power_down) else $error("pdown with nmi high");
  dbg_entry_a: assert property ($fell(o_sys_reset)
    && i_pins.debug_reset_pin |-> o_boot.debug_active
    && o_boot.hw_cfg_enable) else $error("debug not entered");
  cfg_latch_a: assert property ($fell(o_sys_reset) |->
    o_boot.startup_cfg == {i_pins.startup_cfg_pin_b,
    i_pins.startup_cfg_pin_a}) else $error("startup cfg wrong");
  dbg_reset_a: assert property (o_boot.debug_active
    && !i_pins.debug_reset_pin && !o_sys_reset
    |-> ##[0:6] o_debug_reset) else $error("debug reset missing");
  rel_sync_a: assert property ($fell(o_sys_reset)
    |-> $past(i_pins.reset_input_pin_n, 3)) else $error("early release");
endmodule
bind rnd_reset_nmi_debug_entry rnd_chk i_rnd_chk (.i_clk_sys, .i_rst,
  .i_pins, .i_power_down_instruction, .i_wake, .i_nmi_ack, .o_sys_reset,
  .o_nmi_trap_req, .o_power_down, .o_debug_reset, .o_boot);

// File: rnd_pin_model.sv
// partner: external reset circuit, nmi source and debug host pins
`timescale 1ns/1ps
module rnd_pin_model
  import rnd_pkg::*;
(
  // clock
  input wire logic i_clk_sys,
  // pins toward the block
  output rnd_pkg::rnd_pins_t o_pins
);
  initial o_pins = 5'h18;
  task automatic hold_reset(input logic dbg, input logic [1:0] cfg);
    @(posedge i_clk_sys);
    o_pins <= {1'h0, o_pins.nmi_pin_n, dbg, cfg[0], cfg[1]};
    repeat (MIN_RST_LOW_CYC + 6) @(posedge i_clk_sys);
  endtask
  // debug pin dropped once after entry
  task automatic release_reset(input logic [1:0] cfg);
    o_pins.reset_input_pin_n <= 1'h1;
    repeat (8) @(posedge i_clk_sys);
    o_pins.debug_reset_pin <= 1'h0;
    // cfg pins move on so a stale latch shows
    o_pins.startup_cfg_pin_a <= ~cfg[0];
    o_pins.startup_cfg_pin_b <= ~cfg[1];
  endtask
  task automatic set_nmi(input logic v);
    @(posedge i_clk_sys);
    o_pins.nmi_pin_n <= v;
  endtask
endmodule

// File: rnd_reset_nmi_debug_entry_tb_top.sv
// testbench: boot, nmi and power-down scenarios with a pin model
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin \
  num_errors++; $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module rnd_reset_nmi_debug_entry_tb_top;
  import rnd_pkg::*;
  logic i_clk_sys = 1'h0;
  logic i_rst = 1'h1;
  logic i_power_down_instruction = 1'h0;
  logic i_wake = 1'h0;
  logic i_nmi_ack = 1'h0;
  logic o_sys_reset, o_nmi_trap_req, o_power_down, o_debug_reset;
  rnd_pins_t pins;
  rnd_boot_t o_boot;
  int num_errors = 0;
  int n_tests = 0;
  initial forever #5 i_clk_sys = ~i_clk_sys;
  rnd_pin_model i_rnd_pin_model (.i_clk_sys, .o_pins(pins));
  rnd_reset_nmi_debug_entry i_rnd_reset_nmi_debug_entry (.i_clk_sys,
    .i_rst, .i_pins(pins), .i_power_down_instruction, .i_wake, .i_nmi_ack,
    .o_sys_reset, .o_nmi_trap_req, .o_power_down, .o_debug_reset, .o_boot);
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk_sys);
  endtask
  task automatic t_boot(input logic dbg, input logic [1:0] cfg);
    i_rnd_pin_model.hold_reset(dbg, cfg);
    `CHK("sys_reset", 1'h1, o_sys_reset)
    i_rnd_pin_model.release_reset(cfg);
    `CHK("sys_reset", 1'h0, o_sys_reset)
    `CHK("debug_active", dbg, o_boot.debug_active)
    // synced debug pin low at the fourth edge, pulse one edge later
    tick(5);
    #1;
    `CHK("debug_reset", dbg, o_debug_reset)
    tick(3);
    `CHK("debug_active", 1'h0, o_boot.debug_active)
    `CHK("hw_cfg", dbg, o_boot.hw_cfg_enable)
    `CHK("startup_cfg", cfg, o_boot.startup_cfg)
  endtask
  task automatic t_nmi;
    i_rnd_pin_model.set_nmi(1'h0);
    tick(7);
    `CHK("nmi_req", 1'h1, o_nmi_trap_req)
    i_nmi_ack <= 1'h1;
    tick(1);
    i_nmi_ack <= 1'h0;
    tick(2);
    `CHK("nmi_req", 1'h0, o_nmi_trap_req)
  endtask
  task automatic t_pdown(input logic nmi);
    i_rnd_pin_model.set_nmi(nmi);
    tick(6);
    i_power_down_instruction <= 1'h1;
    tick(1);
    i_power_down_instruction <= 1'h0;
    tick(1);
    `CHK("power_down", ~nmi, o_power_down)
    i_wake <= 1'h1;
    tick(1);
    i_wake <= 1'h0;
    tick(1);
    `CHK("power_down", 1'h0, o_power_down)
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    tick(16);
    i_rst <= 1'h0;
    for (int k = 0; k < 4; k++) t_boot(k[0], k[1:0]);
    t_nmi();
    t_pdown(1'h0);
    t_pdown(1'h1);
    report_and_stop();
  end
  // run needs about 190 cycles
  initial begin
    #20000;
    num_errors++;
    report_and_stop();
  end
endmodule
